// ---- verilog/converter_interlock.sv ----
// converter and drive unit end: alarms, contactor, power stage, brake release
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module converter_interlock #(
   parameter int unsigned SW_W = interlock_pkg::SW_W
) (
   input  wire logic            core_clk,
   input  wire logic            rst,
   interlock_if.device          link,
   input  wire logic            conv_fault_cause,
   input  wire logic            conv_fault_resettable,
   input  wire logic            drive_fault_cause,
   input  wire logic            cap_charged,
   input  wire logic            ext_dyn_brake_fitted,
   input  wire logic [SW_W-1:0] converter_setting_switch,
   output logic                 contactor_drive_out_a,
   output logic                 power_stage_enable,
   output logic                 dyn_brake_on,
   output logic                 alarm_contact_bc,
   output logic                 alarm_contact_ac
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   interlock_pkg::servo_state_t state;
   interlock_pkg::servo_state_t next_state;
   logic conv_alarm;
   logic drive_alarm;
   logic contactor_mode;
   logic started;
   logic warning;
   logic servo_on_d;
   logic main_power_present;
   logic servo_active;
   logic conv_trip;
   logic run_allowed;
   logic servo_on_rise;
   logic reset_cmd;

   assign main_power_present = contactor_mode ? contactor_drive_out_a
                                              : link.ext_main_power_on;
   assign servo_active  = link.servo_on_cmd && (state != interlock_pkg::SERVO_OFF);
   assign conv_trip     = conv_fault_cause && servo_active;
   assign servo_on_rise = link.servo_on_cmd && !servo_on_d;
   assign reset_cmd     = link.error_reset_cmd || link.cpu_reset_cmd;
   // the host is trusted to pulse the error reset after alarms clear
   assign run_allowed   = link.servo_on_cmd && !conv_alarm && !drive_alarm
                          && link.forced_stop_input && main_power_present;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         servo_on_d <= 1'b0;
         started    <= 1'b0;
      end else begin
         servo_on_d <= link.servo_on_cmd;
         started    <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // alarms
   // ------------------------------------------------------------
   // set wins over clear; only a power cycle (rst) clears the other class
   always_ff @(posedge core_clk) begin
      if (rst) begin
         conv_alarm <= 1'b0;
      end else if (conv_trip) begin
         conv_alarm <= 1'b1;
      end else if (servo_on_rise && conv_fault_resettable && !conv_fault_cause) begin
         conv_alarm <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         drive_alarm <= 1'b0;
      end else if (conv_trip || drive_fault_cause) begin
         drive_alarm <= 1'b1;
      end else if (reset_cmd && !conv_alarm) begin
         drive_alarm <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // contactor and mode
   // ------------------------------------------------------------
   // changing mode with power on could drop the contactor under load
   always_ff @(posedge core_clk) begin
      if (rst) begin
         contactor_mode <= interlock_pkg::MODE_RESET;
      end else if (!main_power_present) begin
         contactor_mode <= (converter_setting_switch != interlock_pkg::SW_CONTACTOR_OFF);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         contactor_drive_out_a <= 1'b0;
      end else begin
         contactor_drive_out_a <= contactor_mode && started && !conv_alarm
                                  && !drive_alarm
                                  && link.forced_stop_input;
      end
   end

   // ------------------------------------------------------------
   // servo sequence
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         interlock_pkg::SERVO_OFF: begin
            if (run_allowed) begin
               next_state = interlock_pkg::SERVO_CHARGE;
            end
         end
         interlock_pkg::SERVO_CHARGE: begin
            if (!run_allowed) begin
               next_state = interlock_pkg::SERVO_OFF;
            end else if (cap_charged) begin
               next_state = interlock_pkg::SERVO_RUN;
            end
         end
         interlock_pkg::SERVO_RUN: begin
            if (!run_allowed) begin
               next_state = interlock_pkg::SERVO_OFF;
            end else if (!cap_charged) begin
               next_state = interlock_pkg::SERVO_CHARGE;
            end
         end
         default: begin
            next_state = interlock_pkg::SERVO_OFF;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= interlock_pkg::SERVO_OFF;
      end else begin
         state <= next_state;
      end
   end

   // resumes by itself once the stop input returns
   always_ff @(posedge core_clk) begin
      if (rst) begin
         power_stage_enable        <= 1'b0;
         link.brake_release_output <= 1'b0;
      end else begin
         power_stage_enable        <= (next_state == interlock_pkg::SERVO_RUN);
         link.brake_release_output <= (next_state == interlock_pkg::SERVO_RUN);
      end
   end

   // ------------------------------------------------------------
   // warning, brake and alarm contact
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         warning <= 1'b0;
      end else if (!link.forced_stop_input && link.servo_on_cmd) begin
         warning <= 1'b1;
      end else if (link.forced_stop_input) begin
         warning <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         dyn_brake_on     <= 1'b0;
         alarm_contact_bc <= 1'b1;
         alarm_contact_ac <= 1'b0;
      end else begin
         dyn_brake_on     <= ext_dyn_brake_fitted && drive_alarm;
         alarm_contact_bc <= !conv_alarm;
         alarm_contact_ac <= conv_alarm;
      end
   end

   assign link.conv_alarm               = conv_alarm;
   assign link.drive_alarm              = drive_alarm;
   assign link.main_circuit_off_warning = warning;
   assign link.power_stage_ready        = power_stage_enable;
   assign link.contactor_mode           = contactor_mode;
endmodule
`default_nettype wire

// ---- verilog/interlock_pkg.sv ----
// shared constants for the converter alarm and forced-stop interlock
package interlock_pkg;
   // ------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned DB_DELAY_MS     = 50;
   localparam int unsigned DB_DELAY_CYCLES = (DB_DELAY_MS * (CLK_HZ / 1000));

   // ------------------------------------------------------------
   // converter setting switch
   // ------------------------------------------------------------
   localparam int unsigned SW_W            = 4;
   localparam logic [3:0]  SW_CONTACTOR_OFF = 4'h1;
   localparam logic        MODE_RESET      = 1'b1;

   // ------------------------------------------------------------
   // controller register map
   // ------------------------------------------------------------
   localparam logic [11:0] CTRL_OFFSET   = 12'h000;
   localparam logic [11:0] CMD_OFFSET    = 12'h004;
   localparam logic [11:0] STATUS_OFFSET = 12'h008;

   localparam int unsigned CTRL_SERVO_ON_BIT   = 0;
   localparam int unsigned CTRL_MAIN_REQ_BIT   = 1;
   localparam int unsigned CTRL_SW_STOP_BIT    = 2;
   localparam logic [2:0]  CTRL_RESET          = 3'h0;

   localparam int unsigned CMD_ERR_RESET_BIT   = 0;
   localparam int unsigned CMD_CPU_RESET_BIT   = 1;

   localparam int unsigned ST_CONV_ALARM_BIT   = 0;
   localparam int unsigned ST_DRIVE_ALARM_BIT  = 1;
   localparam int unsigned ST_WARNING_BIT      = 2;
   localparam int unsigned ST_BRAKE_REL_BIT    = 3;
   localparam int unsigned ST_STAGE_BIT        = 4;
   localparam int unsigned ST_EXT_MAIN_BIT     = 5;
   localparam int unsigned ST_FSTOP_BIT        = 6;
   localparam int unsigned ST_MODE_BIT         = 7;
   localparam int unsigned ST_OTHER_ALARM_BIT  = 8;
   localparam int unsigned ST_BLOCK_BIT        = 9;

   // ------------------------------------------------------------
   // drive servo sequence
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      SERVO_OFF    = 3'b001,
      SERVO_CHARGE = 3'b010,
      SERVO_RUN    = 3'b100
   } servo_state_t;
endpackage

// ---- verilog/interlock_if.sv ----
// link between the motion controller and the converter/drive pair
`timescale 1ns/1ps
`default_nettype none
interface interlock_if;
   logic servo_on_cmd;
   logic error_reset_cmd;
   logic cpu_reset_cmd;
   logic forced_stop_input;
   logic ext_main_power_on;
   logic conv_alarm;
   logic drive_alarm;
   logic main_circuit_off_warning;
   logic brake_release_output;
   logic power_stage_ready;
   logic contactor_mode;

   modport device (
      input  servo_on_cmd, error_reset_cmd, cpu_reset_cmd, forced_stop_input,
             ext_main_power_on,
      output conv_alarm, drive_alarm, main_circuit_off_warning,
             brake_release_output, power_stage_ready, contactor_mode
   );
   modport controller (
      output servo_on_cmd, error_reset_cmd, cpu_reset_cmd, forced_stop_input,
             ext_main_power_on,
      input  conv_alarm, drive_alarm, main_circuit_off_warning,
             brake_release_output, power_stage_ready, contactor_mode
   );
endinterface
`default_nettype wire

// ---- verilog/hold_off_timer.sv ----
// hold-off timer: done goes high a fixed number of cycles after restart
`timescale 1ns/1ps
`default_nettype none
module hold_off_timer #(
   parameter int unsigned CYCLES = 500_000
) (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic restart,
   output logic      done
);
   logic [31:0] count;

   // starts expired so power-up is not delayed for nothing
   always_ff @(posedge core_clk) begin
      if (rst) begin
         count <= 32'h0;
      end else if (restart) begin
         count <= CYCLES[31:0];
      end else if (count != 32'h0) begin
         count <= count - 32'h1;
      end
   end

   assign done = (count == 32'h0) && !restart;
endmodule
`default_nettype wire

// ---- verilog/motion_sequencer.sv ----
// controller end: external sequence, forced stop and reset commands over apb
`timescale 1ns/1ps
`default_nettype none
module motion_sequencer #(
   parameter int unsigned DB_CYCLES = interlock_pkg::DB_DELAY_CYCLES
) (
   input  wire logic        core_clk,
   input  wire logic        rst,
   interlock_if.controller  link,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        other_axis_alarm,
   output logic             axis_forced_stop_input,
   output logic             ext_brake_engage
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [2:0]  ctrl;
   logic        setup;
   logic        access_wr;
   logic        mapped;
   logic        any_alarm;
   logic        resume_block;
   logic        auto_err_reset;
   logic        delay_done;
   logic [31:0] status;

   assign setup     = psel && !penable;
   assign access_wr = psel && penable && pwrite;
   assign mapped    = (paddr == interlock_pkg::CTRL_OFFSET)
                      || (paddr == interlock_pkg::CMD_OFFSET)
                      || (paddr == interlock_pkg::STATUS_OFFSET);
   assign pready    = 1'b1;
   assign pslverr   = psel && penable && !mapped;
   assign any_alarm = link.conv_alarm || link.drive_alarm || other_axis_alarm;

   always_comb begin
      status = 32'h0;
      status[interlock_pkg::ST_CONV_ALARM_BIT]  = link.conv_alarm;
      status[interlock_pkg::ST_DRIVE_ALARM_BIT] = link.drive_alarm;
      status[interlock_pkg::ST_WARNING_BIT]     = link.main_circuit_off_warning;
      status[interlock_pkg::ST_BRAKE_REL_BIT]   = link.brake_release_output;
      status[interlock_pkg::ST_STAGE_BIT]       = link.power_stage_ready;
      status[interlock_pkg::ST_EXT_MAIN_BIT]    = link.ext_main_power_on;
      status[interlock_pkg::ST_FSTOP_BIT]       = link.forced_stop_input;
      status[interlock_pkg::ST_MODE_BIT]        = link.contactor_mode;
      status[interlock_pkg::ST_OTHER_ALARM_BIT] = other_axis_alarm;
      status[interlock_pkg::ST_BLOCK_BIT]       = resume_block;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl <= interlock_pkg::CTRL_RESET;
      end else if (access_wr && (paddr == interlock_pkg::CTRL_OFFSET)) begin
         ctrl <= pwdata[2:0];
      end
   end

   // read data is captured in setup so the access phase answers at once
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prdata <= 32'h0;
      end else if (setup && !pwrite) begin
         if (paddr == interlock_pkg::CTRL_OFFSET) begin
            prdata <= {29'h0, ctrl};
         end else if (paddr == interlock_pkg::STATUS_OFFSET) begin
            prdata <= status;
         end else begin
            prdata <= 32'h0;
         end
      end
   end

   // ------------------------------------------------------------
   // reset commands and resume block
   // ------------------------------------------------------------
   assign auto_err_reset = resume_block && !any_alarm && !link.error_reset_cmd;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         link.error_reset_cmd <= 1'b0;
         link.cpu_reset_cmd   <= 1'b0;
      end else begin
         link.error_reset_cmd <= auto_err_reset
            || (access_wr && (paddr == interlock_pkg::CMD_OFFSET)
                && pwdata[interlock_pkg::CMD_ERR_RESET_BIT]);
         link.cpu_reset_cmd   <= access_wr && (paddr == interlock_pkg::CMD_OFFSET)
                                 && pwdata[interlock_pkg::CMD_CPU_RESET_BIT];
      end
   end

   // an alarm in contactor-off mode holds servo-on off until a reset is sent;
   // servo-on still passes while the converter alarm stands, as only its rise clears it
   always_ff @(posedge core_clk) begin
      if (rst) begin
         resume_block <= 1'b0;
      end else if (any_alarm && !link.contactor_mode) begin
         resume_block <= 1'b1;
      end else if (link.error_reset_cmd) begin
         resume_block <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // forced stop, external main power and brake
   // ------------------------------------------------------------
   // two registers loaded from the same logic drive this axis and the other axes, so they all see the stop together
   always_ff @(posedge core_clk) begin
      if (rst) begin
         link.forced_stop_input <= 1'b0;
         axis_forced_stop_input <= 1'b0;
         link.servo_on_cmd      <= 1'b0;
      end else begin
         link.forced_stop_input <= !any_alarm && !ctrl[interlock_pkg::CTRL_SW_STOP_BIT];
         axis_forced_stop_input <= !any_alarm && !ctrl[interlock_pkg::CTRL_SW_STOP_BIT];
         link.servo_on_cmd      <= ctrl[interlock_pkg::CTRL_SERVO_ON_BIT]
                                   && !(resume_block && !link.conv_alarm);
      end
   end

   // reloads while main power is on and runs out DB_CYCLES after it drops,
   // so a re-close waits for the brake contactor and relay delays
   hold_off_timer #(
      .CYCLES (DB_CYCLES)
   ) hold_off_timer_inst (
      .core_clk (core_clk),
      .rst      (rst),
      .restart  (link.ext_main_power_on),
      .done     (delay_done)
   );

   always_ff @(posedge core_clk) begin
      if (rst) begin
         link.ext_main_power_on <= 1'b0;
      end else begin
         link.ext_main_power_on <= ctrl[interlock_pkg::CTRL_MAIN_REQ_BIT]
                                   && !other_axis_alarm
                                   && !link.conv_alarm
                                   && !link.drive_alarm
                                   && (link.ext_main_power_on || delay_done);
      end
   end

   assign ext_brake_engage = !link.brake_release_output;
endmodule
`default_nettype wire

// ---- sim/interlock_properties.sv ----
// concurrent checks on the controller to converter link
`timescale 1ns/1ps
`default_nettype none
module interlock_properties #(
   parameter int unsigned DB_CYCLES = 20
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic servo_on_cmd,
   input wire logic error_reset_cmd,
   input wire logic cpu_reset_cmd,
   input wire logic forced_stop_input,
   input wire logic ext_main_power_on,
   input wire logic conv_alarm,
   input wire logic drive_alarm,
   input wire logic main_circuit_off_warning,
   input wire logic brake_release_output,
   input wire logic power_stage_ready
);
   logic [15:0] low_run;

   // ------------------------------------------------------------
   // helper: cycles spent with external main power off
   // ------------------------------------------------------------
   // saturates so a long idle stretch never wraps to a small count;
   // reset counts as a long power-off, since the hold-off starts expired
   always_ff @(posedge core_clk) begin
      if (rst) begin
         low_run <= 16'hffff;
      end else if (ext_main_power_on) begin
         low_run <= 16'h0000;
      end else if (low_run != 16'hffff) begin
         low_run <= low_run + 16'h0001;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_alarm_forces_stop: assert property ((conv_alarm || drive_alarm) |=> !forced_stop_input)
      else $error("alarm present but forced stop released");
   a_alarm_drops_main: assert property ((conv_alarm || drive_alarm) |=> !ext_main_power_on)
      else $error("alarm present but main power kept on");
   a_servo_off_ignore: assert property (!servo_on_cmd && !conv_alarm |=> !conv_alarm)
      else $error("converter alarm latched while servo off");
   a_conv_trips_drive: assert property ($rose(conv_alarm) |-> ##[0:1] drive_alarm)
      else $error("converter alarm did not trip drive alarm");
   a_conv_clear_servo: assert property ($fell(conv_alarm) |-> $past(servo_on_cmd))
      else $error("converter alarm cleared without servo on");
   a_drive_clear_cmd: assert property ($fell(drive_alarm) |-> !conv_alarm &&
      ($past(error_reset_cmd) || $past(cpu_reset_cmd) ||
       $past(error_reset_cmd, 2) || $past(cpu_reset_cmd, 2)))
      else $error("drive alarm cleared without reset command");
   a_stop_kills_stage: assert property (!forced_stop_input [*3] |->
      !power_stage_ready && !brake_release_output)
      else $error("power stage or brake release on during forced stop");
   a_stage_needs_run: assert property ($rose(power_stage_ready) |->
      $past(forced_stop_input) && $past(forced_stop_input, 2))
      else $error("power stage enabled without run allowed");
   a_warning_clears: assert property (forced_stop_input [*2] |-> !main_circuit_off_warning)
      else $error("main circuit off warning held after stop released");
   a_warning_raise: assert property ($fell(forced_stop_input) && servo_on_cmd &&
      !conv_alarm && !drive_alarm ##1 !forced_stop_input |-> ##[0:1] main_circuit_off_warning)
      else $error("forced stop did not raise warning");
   a_main_waits_brake: assert property ($rose(ext_main_power_on) |-> low_run >= DB_CYCLES - 1)
      else $error("main power restored before brake delay");

   cover property ($rose(conv_alarm));
   cover property ($rose(main_circuit_off_warning));
   cover property ($rose(ext_main_power_on));
endmodule
`default_nettype wire

// ---- sim/tb_converter_alarm_forced_stop_interlock.sv ----
// self-checking bench joining the controller end to the converter end
`timescale 1ns/1ps
`default_nettype none
module tb_converter_alarm_forced_stop_interlock;
   localparam int unsigned DB = 20;
   logic        core_clk = 1'b0, rst = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdq, msk;
   logic        conv_fault_cause = 1'b0, conv_fault_resettable = 1'b1, drive_fault_cause = 1'b0;
   logic        cap_charged = 1'b0, ext_dyn_brake_fitted = 1'b0, other_axis_alarm = 1'b0;
   logic [3:0]  converter_setting_switch = 4'h0;
   logic        contactor_drive_out_a, power_stage_enable, dyn_brake_on;
   logic        alarm_contact_bc, alarm_contact_ac, axis_forced_stop_input, ext_brake_engage;
   logic        slv;
   int          err_total = 0, comparisons = 0, cycles = 0;

   interlock_if link ();
   converter_interlock converter_interlock_inst (.core_clk(core_clk), .rst(rst), .link(link),
      .conv_fault_cause(conv_fault_cause), .conv_fault_resettable(conv_fault_resettable),
      .drive_fault_cause(drive_fault_cause), .cap_charged(cap_charged),
      .ext_dyn_brake_fitted(ext_dyn_brake_fitted),
      .converter_setting_switch(converter_setting_switch),
      .contactor_drive_out_a(contactor_drive_out_a), .power_stage_enable(power_stage_enable),
      .dyn_brake_on(dyn_brake_on), .alarm_contact_bc(alarm_contact_bc),
      .alarm_contact_ac(alarm_contact_ac));
   motion_sequencer #(.DB_CYCLES(DB)) motion_sequencer_inst (.core_clk(core_clk), .rst(rst),
      .link(link), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .other_axis_alarm(other_axis_alarm), .axis_forced_stop_input(axis_forced_stop_input),
      .ext_brake_engage(ext_brake_engage));
   interlock_properties #(.DB_CYCLES(DB)) interlock_properties_inst (.core_clk(core_clk),
      .rst(rst), .servo_on_cmd(link.servo_on_cmd), .error_reset_cmd(link.error_reset_cmd),
      .cpu_reset_cmd(link.cpu_reset_cmd), .forced_stop_input(link.forced_stop_input),
      .ext_main_power_on(link.ext_main_power_on), .conv_alarm(link.conv_alarm),
      .drive_alarm(link.drive_alarm), .main_circuit_off_warning(link.main_circuit_off_warning),
      .brake_release_output(link.brake_release_output),
      .power_stage_ready(link.power_stage_ready));

   // ------------------------------------------------------------
   // clock, timeout and verdict
   // ------------------------------------------------------------
   initial begin
      forever #50 core_clk = ~core_clk;
   end

   // the whole sequence needs well under a thousand cycles
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_total = err_total + 1;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      if (err_total == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // ------------------------------------------------------------
   // apb master and shorthand
   // ------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // holds the request until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rdq = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic ctrl(input logic [2:0] v, input int w);
      apb(1'b1, interlock_pkg::CTRL_OFFSET, {29'h0, v});
      tick(w);
   endtask

   task automatic cmd(input logic [1:0] v, input int w);
      apb(1'b1, interlock_pkg::CMD_OFFSET, {30'h0, v});
      tick(w);
   endtask

   task automatic st(input logic [31:0] exp);
      apb(1'b0, interlock_pkg::STATUS_OFFSET, 32'h0);
      chk("status", exp, rdq & msk);
   endtask

   // contactor, stage, dynamic brake, contact b-c, contact a-c
   task automatic dev(input logic [4:0] exp);
      chk("device_outputs", {27'h0, exp}, {27'h0, contactor_drive_out_a, power_stage_enable,
         dyn_brake_on, alarm_contact_bc, alarm_contact_ac});
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      msk = 32'h3df;
      tick(20);
      rst <= 1'b0;
      tick(4);
      st(32'h0c0);
      apb(1'b0, interlock_pkg::CTRL_OFFSET, 32'h0);
      chk("ctrl_reset", 32'h0, rdq);
      apb(1'b0, 12'h00c, 32'h0);
      chk("unmapped_read", 32'h1, {rdq[30:0], slv});
      ctrl(3'h3, 8);
      dev(5'b10010);
      st(32'h0c0);
      cap_charged <= 1'b1;
      tick(6);
      st(32'h0d8);
      chk("brake_engage", 32'h0, {31'h0, ext_brake_engage});
      ctrl(3'h7, 6);
      st(32'h084);
      dev(5'b00010);
      ctrl(3'h3, 8);
      st(32'h0d8);
      dev(5'b11010);
      ctrl(3'h2, 4);
      conv_fault_cause <= 1'b1;
      tick(5);
      st(32'h0c0);
      conv_fault_cause <= 1'b0;
      ctrl(3'h3, 8);
      conv_fault_cause <= 1'b1;
      tick(5);
      st(32'h087);
      dev(5'b00001);
      chk("axis_forced_stop", 32'h0, {31'h0, axis_forced_stop_input});
      conv_fault_cause <= 1'b0;
      cmd(2'h1, 4);
      st(32'h087);
      ctrl(3'h2, 4);
      ctrl(3'h3, 4);
      st(32'h086);
      cmd(2'h1, 10);
      st(32'h0d8);
      ext_dyn_brake_fitted <= 1'b1;
      drive_fault_cause <= 1'b1;
      tick(5);
      st(32'h086);
      dev(5'b00110);
      cmd(2'h2, 4);
      st(32'h086);
      drive_fault_cause <= 1'b0;
      cmd(2'h2, 10);
      st(32'h0d8);
      other_axis_alarm <= 1'b1;
      tick(5);
      st(32'h184);
      other_axis_alarm <= 1'b0;
      tick(8);
      st(32'h0d8);
      converter_setting_switch <= interlock_pkg::SW_CONTACTOR_OFF;
      rst <= 1'b1;
      tick(3);
      rst <= 1'b0;
      tick(4);
      msk = 32'h3ff;
      st(32'h040);
      ctrl(3'h3, DB + 12);
      st(32'h078);
      dev(5'b01010);
      msk = 32'h3df;
      ctrl(3'h7, 6);
      st(32'h004);
      ctrl(3'h3, 8);
      st(32'h058);
      msk = 32'h3ff;
      conv_fault_cause <= 1'b1;
      tick(5);
      st(32'h207);
      conv_fault_cause <= 1'b0;
      ctrl(3'h2, 4);
      ctrl(3'h3, 4);
      st(32'h206);
      cmd(2'h1, 10);
      st(32'h078);
      tally_and_finish();
   end
endmodule
`default_nettype wire
